// ===== verilog/ao_default_ctrl.sv
// Purpose: Per-channel output value selection for an eight-channel analog output.
// Assumes: Condition inputs are asynchronous pins; registers on a plain word port.
// Notes: Default and scale values are sixteen-bit signed integers; ramp rates are sixteen-bit unsigned.
//
// Behaviour
// - Field-power fault interrupts need their own enable.
// - Over-temperature interrupts need their own enable.
// - Range type: disabled voltage, disabled current, active.
// - Four output ranges, bipolar ten volt default.
// - Integer or float value format per channel.
// - Disabled current drives zero current.
// - Disabled voltage drives zero voltage.
// - Five conditions count as a fault.
// - Hold-last-state keeps last value in fault.
// - Without ramp, fault jumps to default value.
// - With default ramp, ramp toward default value.
// - Normal mode without ramp drives command directly.
// - Normal mode with ramp ramps toward command.
// - Backplane power loss skips the default ramp.
// - First store after power-up skips default ramp.
// - Kept analog power, same configuration keeps outputs.
// - Later reconfigurations use the default ramp.
// - Hot removal or cleared configuration holds values.
// - Service request 24 reset holds all channels.
// - Field power loss forces zero volts, zero amps.
// - Equal scale points mean no scaling.
// - Scaling is linear through two points.
// - Commanded value is returned as feedback.
`timescale 1ns/1ps
`include "ao_default_regs.svh"

module ao_default_ctrl
  import ao_default_pkg::*;
#(
  parameter logic [15:0] UPDATE_CYCLES = 16'(`AO_UPDATE_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic outputs_enabled,
  input wire logic backplane_ok,
  input wire logic cpu_comm_ok,
  input wire logic io_comm_ok,
  input wire logic field_power_ok,
  input wire logic over_temp,
  input wire logic hot_removed,
  input wire logic config_cleared,
  input wire logic analog_power_kept,
  output logic [NCH-1:0][15:0] dac_code,
  output logic [NCH-1:0][1:0] range_sel,
  output logic [NCH-1:0] volt_zero,
  output logic [NCH-1:0] curr_zero,
  output logic module_irq
);

  localparam int C_OE = 0;
  localparam int C_BP = 1;
  localparam int C_CPU = 2;
  localparam int C_IO = 3;
  localparam int C_FLD = 4;
  localparam int C_OT = 5;
  localparam int C_HOT = 6;
  localparam int C_CLR = 7;
  localparam int C_KEPT = 8;

  ao_state_s st;
  ao_state_s nx;

  // Values beyond sixteen bits saturate rather than wrap.
  function automatic logic [15:0] float_to_int(input logic [31:0] f);
    logic [7:0] e;
    logic [23:0] m;
    logic [23:0] mag;
    logic [15:0] r;
    e = f[30:23];
    m = {1'b1, f[22:0]};
    mag = 24'h000000;
    r = 16'h0000;
    if (e >= 8'h8e) begin
      r = f[31] ? 16'h8000 : 16'h7fff;
    end else if (e >= 8'h7f) begin
      mag = m >> (8'h96 - e);
      r = f[31] ? 16'(-mag[15:0]) : mag[15:0];
    end
    return r;
  endfunction : float_to_int

  function automatic logic [15:0] ramp_step(input logic [15:0] cur, input logic [15:0] tgt,
                                            input logic [15:0] rate);
    logic signed [16:0] diff;
    logic [16:0] mag;
    diff = 17'($signed(tgt)) - 17'($signed(cur));
    mag = diff[16] ? 17'(-diff) : diff;
    if (mag <= {1'b0, rate}) begin
      return tgt;
    end else if (diff[16]) begin
      return 16'(cur - rate);
    end else begin
      return 16'(cur + rate);
    end
  endfunction : ramp_step

  function automatic logic [15:0] scale(input logic [15:0] v, input logic [15:0] elo,
                                        input logic [15:0] ehi, input logic [15:0] clo,
                                        input logic [15:0] chi);
    logic signed [33:0] num;
    logic signed [16:0] den;
    logic signed [33:0] q;
    // Widen before subtracting so full-span scale points cannot overflow.
    num = (34'($signed(v)) - 34'($signed(elo))) * (34'($signed(chi)) - 34'($signed(clo)));
    den = 17'($signed(ehi)) - 17'($signed(elo));
    q = 34'sd0;
    if (elo == clo && ehi == chi) begin
      return v;
    end else if (den == 17'sd0) begin
      return clo;
    end else begin
      q = num / den;
      return 16'(q + 34'($signed(clo)));
    end
  endfunction : scale

  logic field_lost;
  logic fault;
  logic hold_any;
  logic dflt_mode;
  logic no_ramp;
  logic first_keep;
  logic [NCH-1:0][15:0] cur_nxt;
  logic [NCH-1:0][15:0] dac_nxt;

  assign field_lost = !st.filt[C_FLD];
  assign fault = !st.filt[C_OE] | !st.filt[C_BP] | !st.filt[C_CPU] | !st.filt[C_IO] | field_lost;
  assign hold_any = st.filt[C_HOT] | st.filt[C_CLR] | st.hold_all;
  assign dflt_mode = fault | st.reconfig;
  assign no_ramp = !st.filt[C_BP] | (st.reconfig & st.first_pend);
  assign first_keep = st.reconfig & st.first_pend & st.filt[C_KEPT];

  for (genvar i = 0; i < NCH; i++) begin : gch
    logic [15:0] cmd_i;
    logic [15:0] c_n;
    assign cmd_i = st.fmt_float[i] ? float_to_int(st.cmd[i]) : st.cmd[i][15:0];
    always_comb begin
      c_n = st.cur[i];
      if (field_lost || hold_any) begin
        c_n = st.cur[i];
      end else if (dflt_mode) begin
        if (st.hold[i] || first_keep) begin
          c_n = st.cur[i];
        end else if (no_ramp || st.df_rate[i] == 16'h0000) begin
          c_n = st.dflt[i];
        end else if (st.tick) begin
          c_n = ramp_step(st.cur[i], st.dflt[i], st.df_rate[i]);
        end
      end else if (st.en_rate[i] == 16'h0000) begin
        c_n = cmd_i;
      end else if (st.tick) begin
        c_n = ramp_step(st.cur[i], cmd_i, st.en_rate[i]);
      end
    end
    assign cur_nxt[i] = c_n;
    assign dac_nxt[i] = field_lost ? 16'h0000 :
        scale(st.cur[i], st.eng_lo[i], st.eng_hi[i], st.conv_lo[i], st.conv_hi[i]);
  end

  always_comb begin
    logic [2:0] ch;
    logic [2:0] rg;
    ch = addr[5:3];
    rg = addr[2:0];
    nx = st;
    nx.s1 = {analog_power_kept, config_cleared, hot_removed, over_temp, field_power_ok,
             io_comm_ok, cpu_comm_ok, backplane_ok, outputs_enabled};
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    // A change counts only once the second and third stages agree.
    nx.filt = (st.s2 & st.s3) | (st.filt & (st.s2 | st.s3));
    nx.tick = (st.tick_cnt == UPDATE_CYCLES - 16'h0001);
    nx.tick_cnt = nx.tick ? 16'h0000 : st.tick_cnt + 16'h0001;
    nx.cur = cur_nxt;
    nx.dac = dac_nxt;
    for (int i = 0; i < NCH; i++) begin
      nx.curr_zero[i] = field_lost || st.rtype[i] == RT_DIS_CURR;
      nx.volt_zero[i] = field_lost || st.rtype[i] == RT_DIS_VOLT;
    end
    nx.irq = st.irq_en & ((st.fpr_irq_en & field_lost) | (st.ot_irq_en & st.filt[C_OT]));
    nx.rdata = 32'h00000000;
    if (wr) begin
      if (addr[7:6] == 2'b00) begin
        unique case (rg)
          `AO_REG_CMD: nx.cmd[ch] = wdata;
          `AO_REG_CFG: begin
            nx.rtype[ch] = wdata[`AO_CFG_RTYPE_LSB +: 2];
            nx.rng[ch] = wdata[`AO_CFG_RANGE_LSB +: 2];
            nx.fmt_float[ch] = wdata[`AO_CFG_FMT_BIT];
            nx.hold[ch] = wdata[`AO_CFG_HOLD_BIT];
          end
          `AO_REG_DFLT: nx.dflt[ch] = wdata[15:0];
          `AO_REG_EN_RATE: nx.en_rate[ch] = wdata[15:0];
          `AO_REG_DF_RATE: nx.df_rate[ch] = wdata[15:0];
          `AO_REG_ENG: begin
            nx.eng_lo[ch] = wdata[15:0];
            nx.eng_hi[ch] = wdata[31:16];
          end
          `AO_REG_CONV: begin
            nx.conv_lo[ch] = wdata[15:0];
            nx.conv_hi[ch] = wdata[31:16];
          end
          `AO_REG_OUT: begin
          end
        endcase
      end else if (addr == `AO_REG_MCFG) begin
        nx.irq_en = wdata[`AO_MCFG_IRQ_BIT];
        nx.fpr_irq_en = wdata[`AO_MCFG_FPR_BIT];
        nx.ot_irq_en = wdata[`AO_MCFG_OT_BIT];
      end else if (addr == `AO_REG_CTRL) begin
        nx.reconfig = wdata[`AO_CTRL_RECFG_BIT];
        // Leaving reconfiguration is the configuration store.
        if (st.reconfig && !wdata[`AO_CTRL_RECFG_BIT]) begin
          nx.first_pend = 1'b0;
          nx.hold_all = 1'b0;
        end
      end else if (addr == `AO_REG_SVC && wdata == `AO_SVC_RESET_CODE) begin
        nx.hold_all = 1'b1;
      end
    end
    if (rd) begin
      if (addr[7:6] == 2'b00) begin
        unique case (rg)
          `AO_REG_CMD: nx.rdata = st.cmd[ch];
          `AO_REG_CFG: nx.rdata = {26'h0, st.hold[ch], st.fmt_float[ch], st.rng[ch],
                                   st.rtype[ch]};
          `AO_REG_DFLT: nx.rdata = {16'h0, st.dflt[ch]};
          `AO_REG_EN_RATE: nx.rdata = {16'h0, st.en_rate[ch]};
          `AO_REG_DF_RATE: nx.rdata = {16'h0, st.df_rate[ch]};
          `AO_REG_ENG: nx.rdata = {st.eng_hi[ch], st.eng_lo[ch]};
          `AO_REG_CONV: nx.rdata = {st.conv_hi[ch], st.conv_lo[ch]};
          `AO_REG_OUT: nx.rdata = {st.dac[ch], st.cur[ch]};
        endcase
      end else if (addr == `AO_REG_MCFG) begin
        nx.rdata = {29'h0, st.ot_irq_en, st.fpr_irq_en, st.irq_en};
      end else if (addr == `AO_REG_CTRL) begin
        nx.rdata = {31'h0, st.reconfig};
      end else if (addr == `AO_REG_STAT) begin
        nx.rdata = {20'h0, fault, st.hold_all, st.first_pend, st.filt};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      for (int i = 0; i < NCH; i++) begin
        st.rtype[i] <= RT_DIS_CURR;
        st.rng[i] <= RG_BIPOLAR_10V;
        st.eng_lo[i] <= `AO_SCALE_LO_RST;
        st.eng_hi[i] <= `AO_SCALE_HI_RST;
        st.conv_lo[i] <= `AO_SCALE_LO_RST;
        st.conv_hi[i] <= `AO_SCALE_HI_RST;
        st.dflt[i] <= `AO_VALUE_RST;
      end
      st.fmt_float <= '1;
      st.first_pend <= 1'b1;
      st.curr_zero <= '1;
    end else if (ce) begin
      st <= nx;
    end
  end

  assign rdata = st.rdata;
  assign dac_code = st.dac;
  assign range_sel = st.rng;
  assign volt_zero = st.volt_zero;
  assign curr_zero = st.curr_zero;
  assign module_irq = st.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_field_zero: assert property (ce && field_lost |=> dac_code[0] == 16'h0000 && volt_zero[0]
      && curr_zero[0]) else $error("field loss did not zero channel 0");
  a_irq_fpr_gate: assert property (ce && !st.fpr_irq_en && !st.filt[C_OT] |=> !module_irq)
      else $error("field power interrupt without its enable");
  a_irq_ot_gate: assert property (ce && st.irq_en && st.ot_irq_en && st.filt[C_OT]
      |=> module_irq) else $error("over-temperature interrupt missing");
  a_dis_current: assert property (ce && st.rtype[0] == RT_DIS_CURR |=> curr_zero[0])
      else $error("disabled current channel drives current");
  a_dis_voltage: assert property (ce && st.rtype[0] == RT_DIS_VOLT |=> volt_zero[0])
      else $error("disabled voltage channel drives voltage");
  a_hold_last: assert property (ce && dflt_mode && st.hold[0] |=> $stable(st.cur[0]))
      else $error("hold-last-state channel changed");
  a_dflt_jump: assert property (ce && dflt_mode && !hold_any && !st.hold[0] && !first_keep
      && no_ramp && !field_lost |=> st.cur[0] == $past(st.dflt[0]))
      else $error("default not applied at once");
  a_direct_cmd: assert property (ce && !dflt_mode && !hold_any && st.en_rate[0] == 16'h0000
      |=> st.cur[0] == $past(gch[0].cmd_i)) else $error("command not driven directly");
  a_svc_hold: assert property (ce && st.hold_all ##1 ce && st.hold_all |-> $stable(st.cur[0]))
      else $error("outputs moved after module reset request");
  a_no_scale: assert property (ce && !field_lost && st.eng_lo[0] == st.conv_lo[0]
      && st.eng_hi[0] == st.conv_hi[0] |=> dac_code[0] == $past(st.cur[0]))
      else $error("scaling applied with equal points");

endmodule : ao_default_ctrl

// ===== verilog/ao_default_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: Word-indexed register port, eight output channels.
// Notes: Offsets are word indices on the plain register port.
`ifndef AO_DEFAULT_REGS_SVH
`define AO_DEFAULT_REGS_SVH

`define AO_CH_STRIDE 8
`define AO_REG_CMD 3'h0
`define AO_REG_CFG 3'h1
`define AO_REG_DFLT 3'h2
`define AO_REG_EN_RATE 3'h3
`define AO_REG_DF_RATE 3'h4
`define AO_REG_ENG 3'h5
`define AO_REG_CONV 3'h6
`define AO_REG_OUT 3'h7
`define AO_REG_MCFG 8'h40
`define AO_REG_CTRL 8'h41
`define AO_REG_SVC 8'h42
`define AO_REG_STAT 8'h43

`define AO_CFG_RTYPE_LSB 0
`define AO_CFG_RANGE_LSB 2
`define AO_CFG_FMT_BIT 4
`define AO_CFG_HOLD_BIT 5
`define AO_MCFG_IRQ_BIT 0
`define AO_MCFG_FPR_BIT 1
`define AO_MCFG_OT_BIT 2
`define AO_CTRL_RECFG_BIT 0

`define AO_SVC_RESET_CODE 32'h00000018
`define AO_SCALE_LO_RST 16'h8300
`define AO_SCALE_HI_RST 16'h7d00
`define AO_VALUE_RST 16'h0000

`define AO_CLK_MHZ 25
`define AO_UPDATE_US 1000
`define AO_UPDATE_CYCLES (`AO_UPDATE_US * `AO_CLK_MHZ)

`endif

// ===== verilog/ao_default_pkg.sv
// Purpose: Types shared by the analog output default control.
// Assumes: Eight channels, sixteen-bit engineering values.
// Notes: The whole module state is one packed struct.
package ao_default_pkg;
  localparam int NCH = 8;
  localparam int NCOND = 9;

  typedef enum logic [1:0] {
    RT_DIS_VOLT = 2'b00,
    RT_DIS_CURR = 2'b01,
    RT_ACTIVE = 2'b10
  } range_type_e;

  typedef enum logic [1:0] {
    RG_BIPOLAR_10V = 2'b00,
    RG_UNIPOLAR_10V = 2'b01,
    RG_4_20MA = 2'b10,
    RG_0_20MA = 2'b11
  } range_e;

  typedef struct packed {
    logic [NCH-1:0][31:0] cmd;
    logic [NCH-1:0][1:0] rtype;
    logic [NCH-1:0][1:0] rng;
    logic [NCH-1:0] fmt_float;
    logic [NCH-1:0] hold;
    logic [NCH-1:0][15:0] dflt;
    logic [NCH-1:0][15:0] en_rate;
    logic [NCH-1:0][15:0] df_rate;
    logic [NCH-1:0][15:0] eng_lo;
    logic [NCH-1:0][15:0] eng_hi;
    logic [NCH-1:0][15:0] conv_lo;
    logic [NCH-1:0][15:0] conv_hi;
    logic [NCH-1:0][15:0] cur;
    logic [NCH-1:0][15:0] dac;
    logic [NCH-1:0] volt_zero;
    logic [NCH-1:0] curr_zero;
    logic irq_en;
    logic fpr_irq_en;
    logic ot_irq_en;
    logic reconfig;
    logic first_pend;
    logic hold_all;
    logic [NCOND-1:0] s1;
    logic [NCOND-1:0] s2;
    logic [NCOND-1:0] s3;
    logic [NCOND-1:0] filt;
    logic [15:0] tick_cnt;
    logic tick;
    logic [31:0] rdata;
    logic irq;
  } ao_state_s;
endpackage : ao_default_pkg

// ===== testbench/host_side_model.sv
// Purpose: Host and rack side model that drives the module condition pins.
// Assumes: One clock; levels change just after a rising edge.
// Notes: Bit order of want follows the status register condition order.
`timescale 1ns/1ps
module host_side_model (
  input wire logic clk,
  input wire logic [8:0] want,
  output logic outputs_enabled,
  output logic backplane_ok,
  output logic cpu_comm_ok,
  output logic io_comm_ok,
  output logic field_power_ok,
  output logic over_temp,
  output logic hot_removed,
  output logic config_cleared,
  output logic analog_power_kept
);
  logic [8:0] lvl = 9'h01f;

  // Levels are registered so they never move in the sampling time step.
  always @(posedge clk) begin
    lvl <= want;
  end

  assign {analog_power_kept, config_cleared, hot_removed, over_temp, field_power_ok,
          io_comm_ok, cpu_comm_ok, backplane_ok, outputs_enabled} = lvl;
endmodule : host_side_model

// ===== testbench/analog_output_default_control_tb_top.sv
// Purpose: Self-checking bench for the analog output default control.
// Assumes: Channel 0 carries the scenarios; scale points equal, so no scaling.
// Notes: Update tick shortened to 4 cycles so ramps finish quickly.
`timescale 1ns/1ps
module analog_output_default_control_tb_top;
  import ao_default_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [8:0] want = 9'h01f;
  logic oe, bp, cpu, io, fp, ot, hr, cc, ak;
  logic [NCH-1:0][15:0] dac_code;
  logic [NCH-1:0][1:0] range_sel;
  logic [NCH-1:0] volt_zero;
  logic [NCH-1:0] curr_zero;
  logic module_irq;
  int failures = 0;
  int n_tests = 0;

  always #20 clk = ~clk;

  host_side_model i_host (.clk(clk), .want(want), .outputs_enabled(oe), .backplane_ok(bp),
    .cpu_comm_ok(cpu), .io_comm_ok(io), .field_power_ok(fp), .over_temp(ot),
    .hot_removed(hr), .config_cleared(cc), .analog_power_kept(ak));

  ao_default_ctrl #(.UPDATE_CYCLES(16'h0004)) i_dut (.clk(clk), .rst(rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .outputs_enabled(oe),
    .backplane_ok(bp), .cpu_comm_ok(cpu), .io_comm_ok(io), .field_power_ok(fp),
    .over_temp(ot), .hot_removed(hr), .config_cleared(cc), .analog_power_kept(ak),
    .dac_code(dac_code), .range_sel(range_sel), .volt_zero(volt_zero),
    .curr_zero(curr_zero), .module_irq(module_irq));

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  // A bound that runs out is a hang: report and stop rather than wait forever.
  task automatic wait_dac(input logic [15:0] v, input int lim);
    int i;
    for (i = 0; i < lim && dac_code[0] !== v; i++) cyc(1);
    chk({16'h0, dac_code[0]}, {16'h0, v});
    if (i == lim) test_done();
  endtask : wait_dac

  // Ramp must be under way after a few ticks, then land exactly on the default.
  task automatic ramp_down();
    cyc(12);
    chk(32'(dac_code[0] !== 16'h0010), 32'h1);
    wait_dac(16'h0010, 250);
  endtask : ramp_down

  initial begin
    cyc(3);
    rst <= 1'b0;
    chk({volt_zero, curr_zero}, 16'h00ff);
    rd_chk(8'h01, 32'h11);
    rd_chk(8'h40, 32'h0);
    rd_chk(8'h50, 32'h0);
    for (int r = 0; r < 4; r++) begin
      wr_reg(8'h01, 32'(2 + 4 * r));
      cyc(3);
      chk(32'(range_sel[0]), 32'(r));
    end
    wr_reg(8'h01, 32'h0);
    cyc(3);
    chk({30'h0, volt_zero[0], curr_zero[0]}, 32'h2);
    wr_reg(8'h01, 32'h02);
    wr_reg(8'h05, 32'h7d008300);
    wr_reg(8'h06, 32'h7d008300);
    wr_reg(8'h02, 32'h10);
    wr_reg(8'h04, 32'h2);
    wr_reg(8'h00, 32'h64);
    wait_dac(16'h0064, 12);
    chk({30'h0, volt_zero[0], curr_zero[0]}, 32'h0);
    rd_chk(8'h00, 32'h64);
    wr_reg(8'h41, 32'h1);
    wait_dac(16'h0010, 4);
    wr_reg(8'h41, 32'h0);
    wait_dac(16'h0064, 8);
    wr_reg(8'h41, 32'h1);
    ramp_down();
    wr_reg(8'h41, 32'h0);
    wait_dac(16'h0064, 8);
    want[0] = 1'b0;
    ramp_down();
    want[0] = 1'b1;
    wait_dac(16'h0064, 12);
    want[1] = 1'b0;
    wait_dac(16'h0010, 8);
    want[1] = 1'b1;
    wait_dac(16'h0064, 12);
    wr_reg(8'h01, 32'h22);
    want[0] = 1'b0;
    cyc(12);
    chk({16'h0, dac_code[0]}, 32'h64);
    want[0] = 1'b1;
    wr_reg(8'h01, 32'h02);
    wr_reg(8'h04, 32'h0);
    for (int b = 0; b < 4; b++) begin
      want[b] = 1'b0;
      wait_dac(16'h0010, 12);
      want[b] = 1'b1;
      wait_dac(16'h0064, 12);
    end
    wr_reg(8'h03, 32'h3);
    wr_reg(8'h00, 32'h70);
    cyc(2);
    chk(32'(dac_code[0] !== 16'h0070), 32'h1);
    wait_dac(16'h0070, 40);
    wr_reg(8'h42, 32'h18);
    want[0] = 1'b0;
    cyc(12);
    chk({16'h0, dac_code[0]}, 32'h70);
    want[0] = 1'b1;
    cyc(8);
    wr_reg(8'h41, 32'h1);
    wr_reg(8'h41, 32'h0);
    wait_dac(16'h0070, 12);
    for (int k = 6; k < 8; k++) begin
      want[k] = 1'b1;
      want[0] = 1'b0;
      cyc(12);
      chk({16'h0, dac_code[0]}, 32'h70);
      want[0] = 1'b1;
      want[k] = 1'b0;
      wait_dac(16'h0070, 12);
    end
    wr_reg(8'h40, 32'h3);
    want[4] = 1'b0;
    wait_dac(16'h0000, 12);
    chk({volt_zero, curr_zero}, 16'hffff);
    chk(32'(module_irq), 32'h1);
    wr_reg(8'h40, 32'h1);
    cyc(3);
    chk(32'(module_irq), 32'h0);
    want[4] = 1'b1;
    want[5] = 1'b1;
    wr_reg(8'h40, 32'h5);
    cyc(10);
    chk(32'(module_irq), 32'h1);
    wr_reg(8'h40, 32'h1);
    cyc(3);
    chk(32'(module_irq), 32'h0);
    rst <= 1'b1;
    cyc(3);
    want = 9'h11f;
    rst <= 1'b0;
    chk({volt_zero, curr_zero}, 16'h00ff);
    cyc(8);
    wr_reg(8'h00, 32'h42c80000);
    wait_dac(16'h0064, 12);
    wr_reg(8'h41, 32'h1);
    cyc(4);
    chk({16'h0, dac_code[0]}, 32'h64);
    test_done();
  end
endmodule : analog_output_default_control_tb_top
